/* memory_mode_pin_config.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Overview of operation
// - the strap on flag pin two is read during reset: low gives full memory mode, high host mode.
// - after reset the chosen memory mode is frozen until the next reset.
// - after reset the three strap pins become ordinary programmable flag pins.
// - full memory mode drives a 14-bit address bus and a 24-bit data bus, top byte also byte address.
// - host mode offers the 16-bit host port with its strobes and ack, address bit 0 and data 23..8.
// - a shared interrupt/flag pin works as interrupt and flag at once.
// - an unmasked shared pin that is asserted, from outside or as own flag, raises its interrupt.
// - a control bit picks serial port or alternate interrupts and flags for the second serial port.
// - the three fixed output flags are always outputs.
// ----------------------------------------------------------------------
module memory_mode_pin_config
    import pin_cfg_pkg::*;
(
    // clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // apb slave
    input  wire logic [PADDR_W-1:0]   paddr,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // programmable flag pins, bits 2..0 double as straps
    input  wire logic [FLAG_N-1:0]    prog_flag_i,
    output logic      [FLAG_N-1:0]    prog_flag_o,
    output logic      [FLAG_N-1:0]    prog_flag_oe,
    // fixed output flags
    output logic      [FIXED_N-1:0]   fixed_output_flags,
    // interrupt requests to the controller
    output logic      [IRQ_N-1:0]     irq_req,
    // external memory pins
    output logic      [ADDR_W-1:0]    ext_address_bus_o,
    output logic      [ADDR_W-1:0]    ext_address_bus_oe,
    input  wire logic [DATA_W-1:0]    ext_data_bus_i,
    output logic      [DATA_W-1:0]    ext_data_bus_o,
    output logic      [DATA_W-1:0]    ext_data_bus_oe,
    // core memory side
    input  wire logic [ADDR_W-1:0]    core_addr,
    input  wire logic [DATA_W-1:0]    core_wdata,
    input  wire logic                 core_data_drive,
    input  wire logic                 core_byte_access,
    input  wire logic [BYTE_W-1:0]    core_byte_addr,
    output logic      [DATA_W-1:0]    core_rdata,
    // host port pins
    input  wire logic [HOST_W-1:0]    host_port_addr_data_i,
    output logic      [HOST_W-1:0]    host_port_addr_data_o,
    output logic      [HOST_W-1:0]    host_port_addr_data_oe,
    input  wire logic                 host_port_write_strobe_n,
    input  wire logic                 host_port_read_strobe_n,
    input  wire logic                 host_port_addr_latch,
    input  wire logic                 host_port_select_n,
    output logic                      host_port_ack_n,
    // core host side
    output host_strobe_t              host_strobes,
    output logic      [HOST_W-1:0]    host_ad_in,
    input  wire logic [HOST_W-1:0]    core_host_rdata,
    input  wire logic                 core_host_drive,
    input  wire logic                 core_host_ack,
    // second serial port pins
    input  wire logic [SER_N-1:0]     ser_pin_i,
    output logic      [SER_N-1:0]     ser_pin_o,
    output logic      [SER_N-1:0]     ser_pin_oe,
    // core serial side
    input  wire logic [SER_N-1:0]     core_ser_o,
    input  wire logic [SER_N-1:0]     core_ser_oe,
    output logic      [SER_N-1:0]     core_ser_i,
    // mode status
    output logic                      host_mode,
    output logic                      mode_locked
);

    // ------------------------------------------------------------------
    // pin synchronisers and strap latch
    // ------------------------------------------------------------------
    host_strobe_t        strobe_raw;
    host_strobe_t        strobe_s;
    logic [SYNC_W-1:0]   pins_raw;
    logic [SYNC_W-1:0]   pins_s;
    logic [FLAG_N-1:0]   flag_in_s;
    logic [DATA_W-1:0]   data_in_s;
    logic [HOST_W-1:0]   host_ad_s;
    logic [SER_N-1:0]    ser_s;
    logic [STRAP_N-1:0]  strap_q;
    mem_mode_t           mode_q;

    assign strobe_raw = {host_port_write_strobe_n, host_port_read_strobe_n,
                         host_port_addr_latch, host_port_select_n};
    assign pins_raw   = {ser_pin_i, strobe_raw, host_port_addr_data_i,
                         ext_data_bus_i, prog_flag_i};
    assign flag_in_s  = pins_s[SYNC_FLAG_LSB +: FLAG_N];
    assign data_in_s  = pins_s[SYNC_DATA_LSB +: DATA_W];
    assign host_ad_s  = pins_s[SYNC_HOST_LSB +: HOST_W];
    assign strobe_s   = pins_s[SYNC_STRB_LSB +: STROBE_N];
    assign ser_s      = pins_s[SYNC_SER_LSB +: SER_N];

    pin_sync u_sync (
        .pclk   (pclk),
        .raw    (pins_raw),
        .synced (pins_s)
    );

    mode_strap_latch u_strap (
        .pclk    (pclk),
        .presetn (presetn),
        .strap_s (flag_in_s[STRAP_N-1:0]),
        .strap_q (strap_q),
        .mode_q  (mode_q),
        .locked  (mode_locked)
    );

    wire full_mode = mode_locked && (mode_q == MODE_FULL_MEM);
    assign host_mode = mode_locked && (mode_q == MODE_HOST);

    // ------------------------------------------------------------------
    // apb register file
    // ------------------------------------------------------------------
    logic                sys_alt_q;
    logic [FLAG_N-1:0]   flag_dir_q;
    logic [FLAG_N:0]     flag_out_q;
    logic [FIXED_N-1:0]  fixed_q;
    logic [IRQ_N-1:0]    mask_q;
    logic [31:0]         rd_word;

    wire wr_en     = psel && penable && pwrite;
    wire setup     = psel && !penable;
    wire hit_sys   = (paddr == OFS_SYS_CTRL);
    wire hit_dir   = (paddr == OFS_FLAG_DIR);
    wire hit_out   = (paddr == OFS_FLAG_OUT);
    wire hit_fixed = (paddr == OFS_FIXED);
    wire hit_mask  = (paddr == OFS_INT_MASK);
    wire hit_fin   = (paddr == OFS_FLAG_IN);
    wire hit_mode  = (paddr == OFS_MODE);
    wire mapped    = hit_sys | hit_dir | hit_out | hit_fixed | hit_mask | hit_fin | hit_mode;
    wire [FIXED_N-1:0] wr_fixed_val = pwdata[FIXED_N-1:0];

    wire [FLAG_N:0]    flag_stat = {ser_s[SER_RX_DATA], flag_in_s};
    wire [STRAP_N+1:0] mode_stat = {strap_q, mode_locked, host_mode};

    assign rd_word = hit_sys   ? 32'(sys_alt_q)  :
                     hit_dir   ? 32'(flag_dir_q) :
                     hit_out   ? 32'(flag_out_q) :
                     hit_fixed ? 32'(fixed_q)    :
                     hit_mask  ? 32'(mask_q)     :
                     hit_fin   ? 32'(flag_stat)  :
                     hit_mode  ? 32'(mode_stat)  : 32'h0000_0000;

    // read data is captured in the setup cycle so the access cycle ends at once
    assign pready = 1'b1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_word;
            pslverr <= !mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_alt_q  <= RST_SYS_ALT;
            flag_dir_q <= RST_FLAG_DIR;
            flag_out_q <= RST_FLAG_OUT;
            fixed_q    <= RST_FIXED;
            mask_q     <= RST_INT_MASK;
        end else if (wr_en) begin
            if (hit_sys)   sys_alt_q  <= pwdata[0];
            if (hit_dir)   flag_dir_q <= pwdata[FLAG_N-1:0];
            if (hit_out)   flag_out_q <= pwdata[FLAG_N:0];
            if (hit_fixed) fixed_q    <= wr_fixed_val;
            if (hit_mask)  mask_q     <= pwdata[IRQ_N-1:0];
        end
    end

    // ------------------------------------------------------------------
    // pin multiplexing, next values
    // ------------------------------------------------------------------
    logic [ADDR_W-1:0]  addr_oe_d;
    logic [DATA_W-1:0]  data_o_d;
    logic [DATA_W-1:0]  data_oe_d;
    logic [HOST_W-1:0]  host_oe_d;
    logic [SER_N-1:0]   ser_o_d;
    logic [SER_N-1:0]   ser_oe_d;
    logic [FLAG_N-1:0]  flag_oe_d;
    logic [IRQ_N-1:0]   irq_d;

    // address pins: all 14 in full mode, only the lowest in host mode
    assign addr_oe_d = full_mode ? FULL_ADDR_OE : (host_mode ? HOST_ADDR_OE : '0);

    // byte accesses put the byte-memory address on the top data byte
    assign data_o_d  = {(core_byte_access ? core_byte_addr : core_wdata[DATA_W-1:UPPER_LSB]),
                        core_wdata[UPPER_LSB-1:0]};
    assign data_oe_d = full_mode ? ((core_data_drive ? FULL_DATA_OE : '0)
                                    | (core_byte_access ? UPPER_DATA_OE : '0)) :
                       (host_mode && core_data_drive) ? HOST_DATA_OE : '0;
    assign core_rdata = host_mode ? (data_in_s & HOST_DATA_OE) : data_in_s;

    // host port lives only in host mode; the core sees idle strobes otherwise
    assign host_oe_d    = {HOST_W{host_mode && core_host_drive}};
    assign host_strobes = host_mode ? strobe_s : HOST_STROBE_IDLE;
    assign host_ad_in   = host_mode ? host_ad_s : '0;

    // straps are never driven before the mode has been latched
    assign flag_oe_d = mode_locked ? flag_dir_q : '0;

    // alternate roles: frames become interrupts, rx data a flag in, tx data a flag out
    assign ser_o_d    = sys_alt_q ? {flag_out_q[ALT_FLAG_BIT], {(SER_N-1){1'b0}}} : core_ser_o;
    assign ser_oe_d   = sys_alt_q ? SER_ALT_OE : core_ser_oe;
    assign core_ser_i = sys_alt_q ? '0 : ser_s;

    // the request reads the pin itself, so an own flag output low also interrupts
    genvar g;
    generate
        for (g = 0; g < IRQ_SHARED_N; g++) begin : g_irq
            assign irq_d[g] = !flag_in_s[IRQ_SHARED_LSB+g] && mask_q[g];
        end
    endgenerate
    assign irq_d[IRQ_ALT0] = sys_alt_q && !ser_s[SER_RX_FRAME] && mask_q[IRQ_ALT0];
    assign irq_d[IRQ_ALT1] = sys_alt_q && !ser_s[SER_TX_FRAME] && mask_q[IRQ_ALT1];

    assign fixed_output_flags = fixed_q;

    // ------------------------------------------------------------------
    // registered pin outputs
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_address_bus_o      <= '0;
            ext_address_bus_oe     <= '0;
            ext_data_bus_o         <= '0;
            ext_data_bus_oe        <= '0;
            host_port_addr_data_o  <= '0;
            host_port_addr_data_oe <= '0;
            host_port_ack_n        <= 1'b1;
            prog_flag_o            <= '0;
            prog_flag_oe           <= '0;
            ser_pin_o              <= '0;
            ser_pin_oe             <= '0;
            irq_req                <= '0;
        end else begin
            ext_address_bus_o      <= core_addr;
            ext_address_bus_oe     <= addr_oe_d;
            ext_data_bus_o         <= data_o_d;
            ext_data_bus_oe        <= data_oe_d;
            host_port_addr_data_o  <= core_host_rdata;
            host_port_addr_data_oe <= host_oe_d;
            host_port_ack_n        <= !(host_mode && core_host_ack);
            prog_flag_o            <= flag_out_q[FLAG_N-1:0];
            prog_flag_oe           <= flag_oe_d;
            ser_pin_o              <= ser_o_d;
            ser_pin_oe             <= ser_oe_d;
            irq_req                <= irq_d;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_flags_quiet;
        @(posedge pclk) disable iff (!presetn)
        !mode_locked |=> (prog_flag_oe == 8'h00);
    endproperty
    a_flags_quiet: assert property (p_flags_quiet) else $error("flag driven before lock");

    property p_flag_dir;
        @(posedge pclk) disable iff (!presetn)
        mode_locked ##1 mode_locked |-> (prog_flag_oe == $past(flag_dir_q));
    endproperty
    a_flag_dir: assert property (p_flag_dir) else $error("flag direction wrong");

    property p_full_bus;
        @(posedge pclk) disable iff (!presetn)
        full_mode |=> (ext_address_bus_oe == 14'h3FFF) && (host_port_addr_data_oe == 16'h0000);
    endproperty
    a_full_bus: assert property (p_full_bus) else $error("full mode bus wrong");

    property p_byte_addr;
        @(posedge pclk) disable iff (!presetn)
        (full_mode && core_byte_access) |=>
            (ext_data_bus_o[23:16] == $past(core_byte_addr)) && (ext_data_bus_oe[23:16] == 8'hFF);
    endproperty
    a_byte_addr: assert property (p_byte_addr) else $error("byte address missing");

    property p_host_bus;
        @(posedge pclk) disable iff (!presetn)
        host_mode |=> (ext_address_bus_oe == 14'h0001) && (ext_data_bus_oe[7:0] == 8'h00)
                      && (host_port_ack_n == !$past(core_host_ack));
    endproperty
    a_host_bus: assert property (p_host_bus) else $error("host mode pins wrong");

    property p_shared_irq;
        @(posedge pclk) disable iff (!presetn)
        (flag_dir_q[5] && mask_q[1] && !flag_in_s[5]) |=> irq_req[1];
    endproperty
    a_shared_irq: assert property (p_shared_irq) else $error("output flag lost its irq");

    property p_irq_masked;
        @(posedge pclk) disable iff (!presetn)
        !mask_q[3] |=> !irq_req[3];
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("masked irq raised");

    property p_serial_alt;
        @(posedge pclk) disable iff (!presetn)
        sys_alt_q |=> (ser_pin_oe == 4'h8) && (ser_pin_o[3] == $past(flag_out_q[8]));
    endproperty
    a_serial_alt: assert property (p_serial_alt) else $error("alternate serial roles wrong");

    property p_fixed_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && hit_fixed) |=> (fixed_output_flags == $past(wr_fixed_val));
    endproperty
    a_fixed_write: assert property (p_fixed_write) else $error("fixed flags not updated");

    property p_unmapped;
        @(posedge pclk) disable iff (!presetn)
        (setup && !mapped) |=> pslverr && (prdata == 32'h0000_0000);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");

endmodule
`default_nettype wire

/* pin_cfg_pkg.sv */
package pin_cfg_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int ADDR_W    = 14;
    localparam int DATA_W    = 24;
    localparam int BYTE_W    = 8;
    localparam int HOST_W    = 16;
    localparam int FLAG_N    = 8;
    localparam int STRAP_N   = 3;
    localparam int FIXED_N   = 3;
    localparam int SER_N     = 4;
    localparam int IRQ_N     = 6;
    localparam int STROBE_N  = 4;
    localparam int PADDR_W   = 12;

    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [PADDR_W-1:0] OFS_SYS_CTRL  = 12'h000;
    localparam logic [PADDR_W-1:0] OFS_FLAG_DIR  = 12'h004;
    localparam logic [PADDR_W-1:0] OFS_FLAG_OUT  = 12'h008;
    localparam logic [PADDR_W-1:0] OFS_FIXED     = 12'h00C;
    localparam logic [PADDR_W-1:0] OFS_INT_MASK  = 12'h010;
    localparam logic [PADDR_W-1:0] OFS_FLAG_IN   = 12'h014;
    localparam logic [PADDR_W-1:0] OFS_MODE      = 12'h018;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int STRAP_MODE_C   = 2;
    localparam int ALT_FLAG_BIT   = 8;
    localparam int IRQ_SHARED_LSB = 4;
    localparam int IRQ_SHARED_N   = 4;
    localparam int IRQ_ALT0       = 4;
    localparam int IRQ_ALT1       = 5;
    localparam int SER_RX_FRAME   = 0;
    localparam int SER_TX_FRAME   = 1;
    localparam int SER_RX_DATA    = 2;
    localparam int SER_TX_DATA    = 3;
    localparam int UPPER_LSB      = DATA_W - BYTE_W;
    localparam int HOST_DATA_LSB  = 8;

    // synchroniser lanes
    localparam int SYNC_FLAG_LSB  = 0;
    localparam int SYNC_DATA_LSB  = SYNC_FLAG_LSB + FLAG_N;
    localparam int SYNC_HOST_LSB  = SYNC_DATA_LSB + DATA_W;
    localparam int SYNC_STRB_LSB  = SYNC_HOST_LSB + HOST_W;
    localparam int SYNC_SER_LSB   = SYNC_STRB_LSB + STROBE_N;
    localparam int SYNC_W         = SYNC_SER_LSB + SER_N;

    // ------------------------------------------------------------------
    // reset values and pin masks
    // ------------------------------------------------------------------
    localparam logic                RST_SYS_ALT   = 1'b0;
    localparam logic [FLAG_N-1:0]   RST_FLAG_DIR  = 8'h00;
    localparam logic [FLAG_N:0]     RST_FLAG_OUT  = 9'h000;
    localparam logic [FIXED_N-1:0]  RST_FIXED     = 3'h0;
    localparam logic [IRQ_N-1:0]    RST_INT_MASK  = 6'h00;
    localparam logic [ADDR_W-1:0]   FULL_ADDR_OE  = 14'h3FFF;
    localparam logic [ADDR_W-1:0]   HOST_ADDR_OE  = 14'h0001;
    localparam logic [DATA_W-1:0]   FULL_DATA_OE  = 24'hFFFFFF;
    localparam logic [DATA_W-1:0]   HOST_DATA_OE  = 24'hFFFF00;
    localparam logic [DATA_W-1:0]   UPPER_DATA_OE = 24'hFF0000;
    localparam logic [SER_N-1:0]    SER_ALT_OE    = 4'h8;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic {
        MODE_FULL_MEM,
        MODE_HOST
    } mem_mode_t;

    typedef struct packed {
        logic write_n;
        logic read_n;
        logic addr_latch;
        logic select_n;
    } host_strobe_t;

    localparam host_strobe_t HOST_STROBE_IDLE = 4'hD;

endpackage

/* pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync
    import pin_cfg_pkg::*;
(
    // clock
    input  wire logic              pclk,
    // pins in, synchronised out
    input  wire logic [SYNC_W-1:0] raw,
    output logic      [SYNC_W-1:0] synced
);

    // ------------------------------------------------------------------
    // two-stage synchroniser per lane
    // ------------------------------------------------------------------
    // no reset here: the strap must flow through while reset is held
    genvar i;
    generate
        for (i = 0; i < SYNC_W; i++) begin : g_lane
            logic meta_q;
            always_ff @(posedge pclk) begin
                meta_q    <= raw[i];
                synced[i] <= meta_q;
            end
        end
    endgenerate

endmodule
`default_nettype wire

/* mode_strap_latch.sv */
`timescale 1ns/1ps
`default_nettype none
module mode_strap_latch
    import pin_cfg_pkg::*;
(
    // clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // synchronised strap pins
    input  wire logic [STRAP_N-1:0] strap_s,
    // latched mode
    output logic      [STRAP_N-1:0] strap_q,
    output mem_mode_t               mode_q,
    output logic                    locked
);

    typedef enum logic {
        ST_WAIT,
        ST_LOCKED
    } latch_state_t;

    latch_state_t state_q;
    latch_state_t state_d;
    wire          capture = (state_q == ST_WAIT);

    assign state_d = ST_LOCKED;
    assign locked  = (state_q == ST_LOCKED);

    // ------------------------------------------------------------------
    // capture once at the first edge after release
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_WAIT;
            strap_q <= '0;
            mode_q  <= MODE_FULL_MEM;
        end else begin
            case (state_q)
                ST_WAIT: begin
                    strap_q <= strap_s;
                    mode_q  <= strap_s[STRAP_MODE_C] ? MODE_HOST : MODE_FULL_MEM;
                    state_q <= state_d;
                end
                ST_LOCKED: begin
                    state_q <= ST_LOCKED;
                end
                default: begin
                    state_q <= ST_WAIT;
                end
            endcase
        end
    end

    property p_strap_capture;
        @(posedge pclk) disable iff (!presetn)
        capture |=> (mode_q == (($past(strap_s[STRAP_MODE_C])) ? MODE_HOST : MODE_FULL_MEM))
                    && (strap_q == $past(strap_s));
    endproperty
    a_strap_capture: assert property (p_strap_capture) else $error("strap not captured");

    property p_mode_frozen;
        @(posedge pclk) disable iff (!presetn)
        locked |=> locked && $stable(mode_q) && $stable(strap_q);
    endproperty
    a_mode_frozen: assert property (p_mode_frozen) else $error("mode changed");

endmodule
`default_nettype wire

/* pin_env_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// far side of the flag pins: strap buffer and outside sources
// ----
module pin_env_model
    import pin_cfg_pkg::*;
(
    // control from the bench
    input  wire logic               presetn,
    input  wire logic [STRAP_N-1:0] strap,
    input  wire logic [FLAG_N-1:0]  ext_lvl,
    // device flag pins
    input  wire logic [FLAG_N-1:0]  flag_o,
    input  wire logic [FLAG_N-1:0]  flag_oe,
    output logic      [FLAG_N-1:0]  flag_i
);
    // the strap buffer drives only while reset is low, then lets go
    always_comb begin
        flag_i = ext_lvl;
        if (!presetn) begin
            flag_i[STRAP_N-1:0] = strap;
        end
        for (int k = 0; k < FLAG_N; k++) begin
            if (flag_oe[k]) begin
                flag_i[k] = flag_o[k];
            end
        end
    end
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import pin_cfg_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
    logic [PADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, fx, seed = 32'h3;
    logic [7:0] prog_flag_i, prog_flag_o, prog_flag_oe, ext_lvl = 8'hFF, core_byte_addr = '0;
    logic [2:0] strap = 3'h0, fixed_output_flags;
    logic [5:0] irq_req;
    logic [13:0] ext_address_bus_o, ext_address_bus_oe, core_addr = '0;
    logic [23:0] ext_data_bus_i = '0, ext_data_bus_o, ext_data_bus_oe, core_wdata = '0;
    logic [15:0] host_port_addr_data_i = '0, core_host_rdata = '0, hoe;
    logic [3:0] ser_pin_o;
    logic [3:0] hstb = 4'hD, ser_pin_i = 4'hF, ser_pin_oe, core_ser_o = '0, core_ser_oe = '0;
    logic core_data_drive = 0, core_byte_access = 0, core_host_ack = 0, core_host_drive = 0;
    logic host_port_ack_n, host_mode, mode_locked;
    int miscompares = 0, samples_checked = 0, msk;
    memory_mode_pin_config i_dut (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
        .prog_flag_i, .prog_flag_o, .prog_flag_oe, .fixed_output_flags, .irq_req,
        .ext_address_bus_o, .ext_address_bus_oe, .ext_data_bus_i, .ext_data_bus_o,
        .ext_data_bus_oe, .core_addr, .core_wdata, .core_data_drive, .core_byte_access,
        .core_byte_addr, .core_rdata(), .host_port_addr_data_i, .host_port_addr_data_o(),
        .host_port_addr_data_oe(hoe), .host_port_write_strobe_n(hstb[3]),
        .host_port_read_strobe_n(hstb[2]), .host_port_addr_latch(hstb[1]),
        .host_port_select_n(hstb[0]), .host_port_ack_n, .host_strobes(), .host_ad_in(),
        .core_host_rdata, .core_host_drive, .core_host_ack, .ser_pin_i, .ser_pin_o,
        .ser_pin_oe, .core_ser_o, .core_ser_oe, .core_ser_i(), .host_mode, .mode_locked
    );
    pin_env_model i_env (
        .presetn, .strap, .ext_lvl, .flag_o(prog_flag_o), .flag_oe(prog_flag_oe),
        .flag_i(prog_flag_i)
    );
    always #12.5 pclk = ~pclk;
    // ----
    // reference model and helpers
    // ----
    function automatic logic [5:0] irq_exp(input int m, input int p, input int a);
        return 6'((((~p >> 4) & 15) | (a ? 48 : 0)) & m);
    endfunction
    function automatic logic [31:0] lfsr();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            miscompares++;
            $display("wrong value at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task automatic apb(input logic [PADDR_W-1:0] a, input logic w, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // a second reset in mid-run shows that only reset can move the mode
    task automatic rst(input logic [2:0] s);
        @(posedge pclk);
        presetn <= 1'b0;
        strap <= s;
        ext_lvl <= {5'h1F, ~s};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask
    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #200000;
        miscompares++;
        conclude();
    end
    // ----
    // scenarios
    // ----
    initial begin
        for (int m = 0; m < 2; m++) begin
            rst({m[0], 2'b10});
            chk(host_mode, m);
            chk(mode_locked, 1);
            apb(OFS_MODE, 0, 0);
            chk(rd, {27'h0, m[0], 2'b10, 1'b1, m[0]});
            apb(OFS_FLAG_IN, 0, 0);
            chk(rd[2:0], {~m[0], 2'b01});
            {core_addr, core_wdata, core_byte_addr, host_port_addr_data_i, core_host_rdata,
             core_ser_o, core_ser_oe, ext_data_bus_i, hstb, core_host_drive}
                <= 115'({lfsr(), lfsr(), lfsr(), lfsr()});
            {core_data_drive, core_byte_access} <= 2'b11;
            repeat (4) @(posedge pclk);
            chk(ext_address_bus_oe, m ? HOST_ADDR_OE : FULL_ADDR_OE);
            chk(ext_data_bus_oe, m ? HOST_DATA_OE : FULL_DATA_OE);
            chk(ext_address_bus_o[0], core_addr[0]);
            if (m == 0) begin
                chk(ext_address_bus_o, core_addr);
                chk(ext_data_bus_o[23:16], core_byte_addr);
            end
            core_host_ack <= 1'b1;
            repeat (3) @(posedge pclk);
            chk(host_port_ack_n, !m);
            chk(hoe, (m && core_host_drive) ? 16'hFFFF : 16'h0000);
            core_host_ack <= 1'b0;
        end
        msk = 'h3F;
        apb(OFS_INT_MASK, 1, msk);
        apb(OFS_FLAG_DIR, 1, 'h24);
        ext_lvl[4] <= 1'b0;
        repeat (5) @(posedge pclk);
        chk(prog_flag_oe, 8'h24);
        chk(irq_req, irq_exp(msk, 'hC0, 0));
        apb(OFS_FLAG_IN, 0, 0);
        chk(rd[5:4], 2'b00);
        ser_pin_i <= 4'h0;
        apb(OFS_FLAG_OUT, 1, 'h100);
        apb(OFS_SYS_CTRL, 1, 1);
        repeat (5) @(posedge pclk);
        chk(ser_pin_oe, SER_ALT_OE);
        chk(ser_pin_o[3], 1);
        chk(irq_req, irq_exp(msk, 'hC0, 1));
        apb(OFS_SYS_CTRL, 1, 0);
        apb(OFS_INT_MASK, 1, 0);
        repeat (5) @(posedge pclk);
        chk(ser_pin_oe, core_ser_oe);
        chk(ser_pin_o, core_ser_o);
        chk(irq_req, irq_exp(0, 'hC0, 0));
        for (int i = 0; i < 4; i++) begin
            fx = lfsr();
            apb(OFS_FIXED, 1, fx);
            @(posedge pclk);
            chk(fixed_output_flags, fx[2:0]);
        end
        apb(12'h020, 0, 0);
        chk(er, 1);
        chk(rd, 0);
        conclude();
    end
endmodule
`default_nettype wire
